// ==== common/msec_consts.vh ====
// Register offsets, field positions, command codes and reset values for the max-address security block.
`ifndef MSEC_CONSTS_VH
`define MSEC_CONSTS_VH

`define MSEC_ADDR_FEATURE   4'h1
`define MSEC_ADDR_DEVSEL    4'h6
`define MSEC_ADDR_COMMAND   4'h7
`define MSEC_ADDR_STATUS    4'h7
`define MSEC_ADDR_ERROR     4'h1
`define MSEC_ADDR_DATA      4'h0
`define MSEC_ADDR_SECSTATE  4'h8
`define MSEC_ADDR_IRQSTAT   4'h9
`define MSEC_ADDR_IRQMASK   4'hA

`define MSEC_CMD_SETMAX     8'hF9
`define MSEC_CMD_RDNATIVE   8'hF8

`define MSEC_FEAT_SETPW     8'h01
`define MSEC_FEAT_LOCK      8'h02
`define MSEC_FEAT_UNLOCK    8'h03
`define MSEC_FEAT_FREEZE    8'h04

`define MSEC_ERR_ABORT      2
`define MSEC_ST_BUSY        7
`define MSEC_ST_READY       6
`define MSEC_ST_FAULT       5
`define MSEC_ST_DRQ         3
`define MSEC_ST_ERR         0

`define MSEC_SS_UNLOCKED    2'h0
`define MSEC_SS_LOCKED      2'h1
`define MSEC_SS_FROZEN      2'h2

`define MSEC_TRIES_RESET    3'h5
`define MSEC_WORDS_SECTOR   9'h100
`define MSEC_PW_FIRST       9'h001
`define MSEC_PW_LAST        9'h010

`define MSEC_IRQ_DONE       0
`define MSEC_IRQ_ABORT      1
`define MSEC_IRQ_DRQ        2
`endif

// ==== hw/msec_pw_store.v ====
// Password word store with compare against a received sector.
`include "msec_consts.vh"
module msec_pw_store
(
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Word stream
    input  wire        wordValid,
    input  wire [8:0]  wordIdx,
    input  wire [15:0] wordData,
    input  wire        storeMode,
    input  wire        cmpStart,
    // Result
    output wire        cmpMatch
);
    reg  [15:0] pwMem [0:15];
    reg         mismatch_ff;
    wire        inPw = (wordIdx >= `MSEC_PW_FIRST) && (wordIdx <= `MSEC_PW_LAST);
    wire [3:0]  slot = wordIdx[3:0] - 4'h1;
    integer     i;

    // The store is volatile: reset clears it, standing in for power loss.
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (i = 0; i < 16; i = i + 1)
                pwMem[i] <= 16'h0000;
        end
        else if (wordValid && inPw && storeMode)
            pwMem[slot] <= wordData;
    end

    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            mismatch_ff <= 1'b0;
        else if (cmpStart)
            mismatch_ff <= 1'b0;
        else if (wordValid && inPw && !storeMode && (pwMem[slot] != wordData))
            mismatch_ff <= 1'b1;
    end

    assign cmpMatch = !mismatch_ff;
endmodule

// ==== hw/msec_setmax_sec.v ====
// Security extension handler of the max-address command, with register port and interrupt.
`include "msec_consts.vh"
module msec_setmax_sec
(
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Register port
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWrStb,
    input  wire        regRdStb,
    output reg  [15:0] regRdData,
    // Interrupt
    output reg         irqOut,
    // Address-set hand-off to the rest of the drive
    output reg         addrSetPulse
);
    localparam IDLE = 2'h0;
    localparam XFER = 2'h1;
    localparam DONE = 2'h2;

    reg  [1:0] phase_ff;
    reg  [1:0] secState_ff;
    reg  [2:0] tries_ff;
    reg  [7:0] feature_ff;
    reg  [7:0] devSel_ff;
    reg  [7:0] errFlags_ff;
    reg  [7:0] statFlags_ff;
    reg        afterNative_ff;
    reg        isSetPw_ff;
    reg  [8:0] wordCnt_ff;
    reg  [2:0] irqStat_ff;
    reg  [2:0] irqMask_ff;
    reg  [2:0] evt;
    reg        nxt_abort;
    reg        nxt_xfer;
    reg  [1:0] nxt_secState;

    wire        cmdWr    = regWrStb && (regAddr == `MSEC_ADDR_COMMAND);
    wire        dataWr   = regWrStb && (regAddr == `MSEC_ADDR_DATA) && (phase_ff == XFER);
    wire        lastWord = dataWr && (wordCnt_ff == `MSEC_WORDS_SECTOR - 9'h001);
    wire        featWr   = regWrStb && (regAddr == `MSEC_ADDR_FEATURE);
    wire        devSelWr = regWrStb && (regAddr == `MSEC_ADDR_DEVSEL);
    wire        stClrWr  = regWrStb && (regAddr == `MSEC_ADDR_IRQSTAT);
    wire        cmpMatch;
    // A command write is only taken while no transfer or completion is pending, so a stray
    // write in mid-sector can neither restart the compare nor skip the attempt count.
    wire        secCmd   = cmdWr && (phase_ff == IDLE) && (regWrData[7:0] == `MSEC_CMD_SETMAX) && !afterNative_ff;
    wire        triesDec = (phase_ff == DONE) && !isSetPw_ff && !cmpMatch;
    wire [2:0]  nxt_irqStat;
    reg  [15:0] nxt_rdData;

    msec_pw_store uStore
    (
        .mclk      (mclk),
        .reset     (reset),
        .wordValid (dataWr),
        .wordIdx   (wordCnt_ff),
        .wordData  (regWrData),
        .storeMode (isSetPw_ff),
        .cmpStart  (secCmd),
        .cmpMatch  (cmpMatch)
    );

    // Decide acceptance of a security sub-function at command write.
    always @*
    begin
        nxt_abort    = 1'b0;
        nxt_xfer     = 1'b0;
        nxt_secState = secState_ff;
        case (feature_ff)
            `MSEC_FEAT_SETPW:
            begin
                if (secState_ff != `MSEC_SS_UNLOCKED)
                    nxt_abort = 1'b1;
                else
                    nxt_xfer = 1'b1;
            end
            `MSEC_FEAT_LOCK:
            begin
                if (secState_ff != `MSEC_SS_UNLOCKED)
                    nxt_abort = 1'b1;
                else
                    nxt_secState = `MSEC_SS_LOCKED;
            end
            `MSEC_FEAT_UNLOCK:
            begin
                if ((secState_ff == `MSEC_SS_FROZEN) || (tries_ff == 3'h0))
                    nxt_abort = 1'b1;
                else
                    nxt_xfer = 1'b1;
            end
            `MSEC_FEAT_FREEZE:
            begin
                if (secState_ff == `MSEC_SS_FROZEN)
                    nxt_abort = 1'b1;
                else
                    nxt_secState = `MSEC_SS_FROZEN;
            end
            default:
                nxt_abort = 1'b1;
        endcase
    end

    // Command sequencing, security state and task-file flags.
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            phase_ff       <= IDLE;
            secState_ff    <= `MSEC_SS_UNLOCKED;
            errFlags_ff    <= 8'h00;
            statFlags_ff   <= 8'h40;
            afterNative_ff <= 1'b0;
            isSetPw_ff     <= 1'b0;
            wordCnt_ff     <= 9'h000;
            addrSetPulse   <= 1'b0;
            evt            <= 3'h0;
        end
        else
        begin
            addrSetPulse <= 1'b0;
            evt          <= 3'h0;
            if (cmdWr && (phase_ff == IDLE))
            begin
                afterNative_ff <= (regWrData[7:0] == `MSEC_CMD_RDNATIVE);
                errFlags_ff    <= 8'h00;
                if (regWrData[7:0] == `MSEC_CMD_SETMAX && afterNative_ff)
                begin
                    // Address setting is refused once locked or frozen.
                    if (secState_ff != `MSEC_SS_UNLOCKED)
                    begin
                        errFlags_ff[`MSEC_ERR_ABORT] <= 1'b1;
                        statFlags_ff <= 8'h41;
                        evt          <= 3'h3;
                    end
                    else
                    begin
                        addrSetPulse <= 1'b1;
                        statFlags_ff <= 8'h40;
                        evt          <= 3'h1;
                    end
                end
                else if (secCmd)
                begin
                    if (nxt_abort)
                    begin
                        errFlags_ff[`MSEC_ERR_ABORT] <= 1'b1;
                        statFlags_ff <= 8'h41;
                        evt          <= 3'h3;
                    end
                    else if (nxt_xfer)
                    begin
                        phase_ff     <= XFER;
                        isSetPw_ff   <= (feature_ff == `MSEC_FEAT_SETPW);
                        wordCnt_ff   <= 9'h000;
                        statFlags_ff <= 8'h48;
                        evt          <= 3'h4;
                    end
                    else
                    begin
                        secState_ff  <= nxt_secState;
                        statFlags_ff <= 8'h40;
                        evt          <= 3'h1;
                    end
                end
                else
                    statFlags_ff <= 8'h40;
            end
            else if (dataWr)
            begin
                // The host delivers one full sector before completion.
                wordCnt_ff <= wordCnt_ff + 9'h001;
                if (lastWord)
                    phase_ff <= DONE;
            end
            else if (phase_ff == DONE)
            begin
                phase_ff <= IDLE;
                if (isSetPw_ff)
                begin
                    secState_ff  <= `MSEC_SS_UNLOCKED;
                    statFlags_ff <= 8'h40;
                    evt          <= 3'h1;
                end
                else if (cmpMatch)
                begin
                    secState_ff  <= `MSEC_SS_UNLOCKED;
                    statFlags_ff <= 8'h40;
                    evt          <= 3'h1;
                end
                else
                begin
                    errFlags_ff[`MSEC_ERR_ABORT] <= 1'b1;
                    statFlags_ff <= 8'h41;
                    evt          <= 3'h3;
                end
            end
        end
    end

    // Task-file registers loaded by the host ahead of a command.
    // A feature write during a transfer is harmless: the running command has latched its kind.
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            feature_ff <= 8'h00;
            devSel_ff  <= 8'h00;
        end
        else
        begin
            if (featWr)
                feature_ff <= regWrData[7:0];
            if (devSelWr)
                devSel_ff <= regWrData[7:0];
        end
    end

    // Attempt counter; only a hard reset or power cycle refills it.
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            tries_ff <= `MSEC_TRIES_RESET;
        else if (triesDec)
            tries_ff <= tries_ff - 3'h1;
    end

    // Per-bit sticky status: an event in the cycle of a write-one clear keeps the bit set.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : gIrqBit
            assign nxt_irqStat[g] = evt[g] | (irqStat_ff[g] & !(stClrWr && regWrData[g]));
        end
    endgenerate

    // Sticky interrupt status; a new event wins over a same-cycle clear.
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            irqStat_ff <= 3'h0;
            irqMask_ff <= 3'h0;
            irqOut     <= 1'b0;
        end
        else
        begin
            irqStat_ff <= nxt_irqStat;
            if (regWrStb && (regAddr == `MSEC_ADDR_IRQMASK))
                irqMask_ff <= regWrData[2:0];
            irqOut <= |(irqStat_ff & irqMask_ff);
        end
    end

    // Read selection; idle and unmapped cycles give zero so stale data never lingers on the port.
    always @*
    begin
        nxt_rdData = 16'h0000;
        if (regRdStb)
        begin
            case (regAddr)
                `MSEC_ADDR_ERROR:    nxt_rdData = {8'h00, errFlags_ff};
                `MSEC_ADDR_STATUS:   nxt_rdData = {8'h00, statFlags_ff};
                `MSEC_ADDR_DEVSEL:   nxt_rdData = {8'h00, devSel_ff};
                `MSEC_ADDR_SECSTATE: nxt_rdData = {8'h00, 1'b0, tries_ff, 2'h0, secState_ff};
                `MSEC_ADDR_IRQSTAT:  nxt_rdData = {13'h0000, irqStat_ff};
                `MSEC_ADDR_IRQMASK:  nxt_rdData = {13'h0000, irqMask_ff};
                default:             nxt_rdData = 16'h0000;
            endcase
        end
    end

    // Read data, valid only in the cycle after the strobe.
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            regRdData <= 16'h0000;
        else
            regRdData <= nxt_rdData;
    end
endmodule

// ==== sim/msec_setmax_sec_asserts.sv ====
// Checker on the register port and outputs of the max-address security block.
`include "msec_consts.vh"
module msec_setmax_sec_asserts
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // Register port
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [15:0] regRdData,
    // Outputs
    input wire logic        irqOut,
    input wire logic        addrSetPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic prevF8_ff;
    // Tracks whether the last command was the native-size read.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            prevF8_ff <= 1'b0;
        else if (regWrStb && regAddr == `MSEC_ADDR_COMMAND)
            prevF8_ff <= regWrData[7:0] == `MSEC_CMD_RDNATIVE;
    end
    rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
        else $error("read data outside read slot");
    status_flags_a: assert property ($past(regRdStb && regAddr == `MSEC_ADDR_STATUS) |->
        regRdData[15:8] == 8'h00 && regRdData[7:5] == 3'b010)
        else $error("status busy, ready or fault wrong");
    error_code_a: assert property ($past(regRdStb && regAddr == `MSEC_ADDR_ERROR) |->
        regRdData == 16'h0000 || regRdData == 16'h0004)
        else $error("error register value illegal");
    tries_range_a: assert property ($past(regRdStb && regAddr == `MSEC_ADDR_SECSTATE) |->
        regRdData[6:4] <= 3'h5 && regRdData[1:0] != 2'h3)
        else $error("attempt count or state illegal");
    unmapped_zero_a: assert property ($past(regRdStb && regAddr > 4'hA) |-> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    set_pulse_one_a: assert property (addrSetPulse |=> !addrSetPulse)
        else $error("address-set pulse too long");
    set_pulse_cause_a: assert property (addrSetPulse |-> $past(prevF8_ff) && $past(regWrStb)
        && $past(regAddr) == `MSEC_ADDR_COMMAND && $past(regWrData[7:0]) == `MSEC_CMD_SETMAX)
        else $error("address-set pulse without preceding pair");
    irq_masked_a: assert property ((regWrStb && regAddr == `MSEC_ADDR_IRQMASK && regWrData[2:0] == 3'h0)
        ##1 !(regWrStb && regAddr == `MSEC_ADDR_IRQMASK) |=> !irqOut)
        else $error("interrupt high with mask clear");
    set_pulse_c: cover property (addrSetPulse);
    irq_high_c: cover property (irqOut);
    abort_read_c: cover property ($past(regRdStb) && regRdData == 16'h0041);
endmodule

// ==== sim/msec_host_model.sv ====
// Host adapter model that drives the task-file register port.
`include "msec_consts.vh"
module msec_host_model
(
    // Clock
    input wire logic    mclk,
    // Register port
    output logic [3:0]  regAddr,
    output logic [15:0] regWrData,
    output logic        regWrStb,
    output logic        regRdStb
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        regAddr = 4'h0;
        regWrData = 16'h0000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
    end
    // Released address and data lines carry the inverse so a stale value never looks held; both strobes drop to zero.
    task automatic xfer(input logic [3:0] a, input logic [15:0] d, input logic wr);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= wr;
        regRdStb <= !wr;
        @(posedge mclk);
        regWrStb <= 1'b0;
        regRdStb <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    task automatic command(input logic [7:0] feat, input logic [7:0] code);
        xfer(`MSEC_ADDR_FEATURE, {8'h00, feat}, 1'b1);
        xfer(`MSEC_ADDR_COMMAND, {8'h00, code}, 1'b1);
    endtask
    task automatic sector(input logic [15:0] pw [16]);
        for (int w = 0; w < 256; w++)
            xfer(`MSEC_ADDR_DATA, (w >= 1 && w <= 16) ? pw[w-1] : 16'h0000, 1'b1);
    endtask
endmodule

// ==== sim/msec_setmax_sec_tb_top.sv ====
// Self-checking bench for the max-address security block.
`include "msec_consts.vh"
module msec_setmax_sec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrStb;
    logic        regRdStb;
    wire  [15:0] regRdData;
    wire         irqOut;
    wire         addrSetPulse;
    logic        rdPend = 1'b0;
    logic [31:0] rng = 32'h8BCD;
    logic [15:0] expQ[$];
    logic [15:0] mskQ[$];
    logic [15:0] pw [16];
    logic [15:0] bad [16];
    logic [15:0] zp [16];
    int err_total = 0;
    int n_compared = 0;
    int pulses = 0;
    int cycles = 0;
    always #4 mclk = ~mclk;
    msec_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb));
    msec_setmax_sec uut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irqOut(irqOut),
        .addrSetPulse(addrSetPulse));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        host.xfer(a, 16'h0000, 1'b0);
    endtask
    task automatic done(input logic ok, input logic [7:0] sec);
        chk(`MSEC_ADDR_STATUS, ok ? 16'h0040 : 16'h0041);
        chk(`MSEC_ADDR_ERROR, ok ? 16'h0000 : 16'h0004);
        chk(`MSEC_ADDR_SECSTATE, {8'h00, sec});
    endtask
    task automatic pwCmd(input logic [7:0] feat, input logic [15:0] p [16]);
        host.command(feat, `MSEC_CMD_SETMAX);
        chk(`MSEC_ADDR_STATUS, 16'h0048);
        host.sector(p);
    endtask
    // Results are compared the cycle after each read strobe, oldest note first.
    always @(posedge mclk)
    begin
        rdPend <= regRdStb;
        if (rdPend)
            cmp16(regRdData & mskQ.pop_front(), expQ.pop_front(), "read data");
        if (addrSetPulse === 1'b1)
            pulses++;
        cycles++;
        if (cycles > 60000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            rng = xs(rng);
            pw[i] = rng[15:0];
            zp[i] = 16'h0000;
        end
        bad = pw;
        bad[4] = ~pw[4];
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        done(1, 8'h50);
        chk(4'hF, 16'h0000);
        host.xfer(`MSEC_ADDR_DEVSEL, {8'h00, pw[0][7:0]}, 1'b1);
        chk(`MSEC_ADDR_DEVSEL, {8'h00, pw[0][7:0]});
        host.xfer(`MSEC_ADDR_IRQMASK, 16'h0007, 1'b1);
        pwCmd(`MSEC_FEAT_SETPW, pw);
        done(1, 8'h50);
        chk(`MSEC_ADDR_IRQSTAT, 16'h0005);
        cmp16({15'h0000, irqOut}, 16'h0001, "irq raised");
        host.xfer(`MSEC_ADDR_IRQSTAT, 16'h0007, 1'b1);
        host.xfer(`MSEC_ADDR_IRQMASK, 16'h0000, 1'b1);
        chk(`MSEC_ADDR_IRQSTAT, 16'h0000);
        cmp16({15'h0000, irqOut}, 16'h0000, "irq cleared");
        $display("test password and interrupt finished");
        host.command(`MSEC_FEAT_LOCK, `MSEC_CMD_SETMAX);
        done(1, 8'h51);
        cmp16({15'h0000, irqOut}, 16'h0000, "irq masked");
        host.command(`MSEC_FEAT_SETPW, `MSEC_CMD_SETMAX);
        done(0, 8'h51);
        host.command(`MSEC_FEAT_LOCK, `MSEC_CMD_SETMAX);
        done(0, 8'h51);
        chk(`MSEC_ADDR_IRQSTAT, 16'h0003);
        pwCmd(`MSEC_FEAT_UNLOCK, bad);
        done(0, 8'h41);
        pwCmd(`MSEC_FEAT_UNLOCK, pw);
        done(1, 8'h40);
        host.command(8'h05, `MSEC_CMD_SETMAX);
        done(0, 8'h40);
        host.command(`MSEC_FEAT_LOCK, `MSEC_CMD_SETMAX);
        for (int t = 3; t >= 0; t--)
        begin
            pwCmd(`MSEC_FEAT_UNLOCK, bad);
            done(0, {1'b0, 3'(t), 4'h1});
        end
        host.command(`MSEC_FEAT_UNLOCK, `MSEC_CMD_SETMAX);
        done(0, 8'h01);
        $display("test lock and unlock finished");
        host.command(`MSEC_FEAT_FREEZE, `MSEC_CMD_SETMAX);
        done(1, 8'h02);
        for (int f = 1; f <= 4; f++)
        begin
            host.command(8'(f), `MSEC_CMD_SETMAX);
            done(0, 8'h02);
        end
        host.command(8'h00, `MSEC_CMD_RDNATIVE);
        host.command(8'h00, `MSEC_CMD_SETMAX);
        done(0, 8'h02);
        cmp16(16'(pulses), 16'h0000, "frozen address-set");
        $display("test freeze finished");
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        done(1, 8'h50);
        host.command(`MSEC_FEAT_LOCK, `MSEC_CMD_SETMAX);
        pwCmd(`MSEC_FEAT_UNLOCK, pw);
        done(0, 8'h41);
        pwCmd(`MSEC_FEAT_UNLOCK, zp);
        done(1, 8'h40);
        host.command(8'h00, `MSEC_CMD_RDNATIVE);
        host.command(8'h00, `MSEC_CMD_SETMAX);
        repeat (2) @(posedge mclk);
        cmp16(16'(pulses), 16'h0001, "address-set pulse");
        $display("test reset and address-set finished");
        repeat (3) @(posedge mclk);
        cmp16(16'(expQ.size()), 16'h0000, "reads left unanswered");
        test_done();
    end
endmodule
bind msec_setmax_sec msec_setmax_sec_asserts sva_i (.mclk(mclk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .irqOut(irqOut), .addrSetPulse(addrSetPulse));
